/* File: core/ppp_pkg.sv */
/*
  shared constants and types for the parallel programming port.
  assumes one 100 mhz clock on both ends.
*/
package ppp_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned ENTRY_WAIT_US = 300;
  localparam int unsigned ENTRY_WAIT_CYC = ENTRY_WAIT_US * CLK_MHZ;
  localparam int unsigned FLASH_PAGE_WORDS = 64;
  localparam int unsigned FLASH_PAGES = 256;
  localparam int unsigned EE_PAGE_BYTES = 4;
  localparam int unsigned EE_PAGES = 256;
  localparam int unsigned ERASE_CYC = 200;
  localparam int unsigned PROG_CYC = 100;
  localparam int unsigned FUSE_BYTES = 3;
  localparam logic [7:0] FUSE_RESET_LO = 8'h62;
  localparam logic [7:0] FUSE_RESET_HI = 8'hd9;
  localparam logic [7:0] FUSE_RESET_EXT = 8'hff;
  localparam logic [7:0] LOCK_RESET = 8'hff;
  localparam int unsigned PRESERVE_EE_BIT = 3;
  localparam logic [7:0] SIG_BYTE0 = 8'h5a; // arbitrary value
  localparam logic [7:0] SIG_BYTE1 = 8'ha5; // arbitrary value
  localparam logic [7:0] SIG_BYTE2 = 8'h3c; // arbitrary value
  localparam logic [7:0] CAL_BYTE = 8'h80;
  localparam logic [1:0] ACT_ADDR = 2'b00;
  localparam logic [1:0] ACT_DATA = 2'b01;
  localparam logic [1:0] ACT_CMD = 2'b10;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;
  typedef enum logic [2:0] {
    PPP_OP_IDLE, PPP_OP_ERASE_MEM, PPP_OP_ERASE_LOCK,
    PPP_OP_FLASH, PPP_OP_EE, PPP_OP_FUSE, PPP_OP_LOCK
  } ppp_op_t;
endpackage

/* File: core/ppp_if.sv */
/*
  pin bundle between the programmer and the programmed device.
  assumes both ends share mclk; the data bus resolves from enables.
*/
`timescale 1ns/1ns
`default_nettype none
interface ppp_if;
  logic       hv_reset;
  logic       load_strobe;
  logic       action_select_lo;
  logic       action_select_hi;
  logic       byte_select_a;
  logic       byte_select_b;
  logic       page_load_strobe;
  logic       write_n;
  logic       output_en_n;
  logic       prog_ready_n_busy;
  logic [7:0] data_dev_o;
  logic       data_dev_oe_n;
  logic [7:0] data_host_o;
  logic       data_host_oe_n;
  logic [7:0] data_bus;
  assign data_bus = !data_dev_oe_n ? data_dev_o :
                    !data_host_oe_n ? data_host_o : 8'hff;
  modport dev (
    input  hv_reset, load_strobe, action_select_lo, action_select_hi,
    input  byte_select_a, byte_select_b, page_load_strobe,
    input  write_n, output_en_n, data_bus,
    output prog_ready_n_busy, data_dev_o, data_dev_oe_n
  );
  modport host (
    output hv_reset, load_strobe, action_select_lo, action_select_hi,
    output byte_select_a, byte_select_b, page_load_strobe,
    output write_n, output_en_n, data_host_o, data_host_oe_n,
    input  prog_ready_n_busy, data_bus
  );
endinterface
`default_nettype wire

/* File: core/ppp_device.sv */
/*
  device end: entry latch, byte loading, page buffers, erase and page
  programming with ready/busy, and read-back on the data bus.
  assumes all pins synchronous to mclk and a programmer keeping its side.
*/
`timescale 1ns/1ns
`default_nettype none
// How it works
// - load strobe acts on action select pair
// - decode the ten command bytes
// - write or read runs last command
// - ready low while programming busy
// - drive data while output enable low, one mclk cycle late
// - first byte select picks high byte
// - second byte select picks second high
// - page load latches data at word
// - entry pins all zero at reset rise
// - programmer waits before first command
// - reset low leaves programming mode
// - command and address kept across operations
// - erase spares fuses, eeprom if preserved
// - locks cleared after memory erase
// - write after erase command starts erase
// - write flash programs whole page buffer
// - low address bits pick word
// - nop command resets write signals
// - eeprom page write on write pulse with first byte select low
// - read flash low or high byte
// - programmer erases before reprogramming
// - reload high address per window
module ppp_device
  import ppp_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sys_rst,
  ppp_if.dev        pins,
  output logic      prog_mode,
  output logic      prog_active
);
  import ppp_pkg::*;

  localparam int FW = $clog2(FLASH_PAGE_WORDS);
  localparam int EW = $clog2(EE_PAGE_BYTES);
  localparam int FA = $clog2(FLASH_PAGE_WORDS * FLASH_PAGES);
  localparam int EA = $clog2(EE_PAGE_BYTES * EE_PAGES);
  localparam int CW = $clog2(ERASE_CYC + PROG_CYC + 1);

  logic [15:0] flash_mem [FLASH_PAGE_WORDS * FLASH_PAGES];
  logic [7:0]  ee_mem [EE_PAGE_BYTES * EE_PAGES];
  logic [15:0] fbuf [FLASH_PAGE_WORDS];
  logic [7:0]  ebuf [EE_PAGE_BYTES];
  logic [7:0]  fuse [FUSE_BYTES];
  logic [7:0]  lock_bits;
  logic [7:0]  cmd;
  logic [15:0] addr;
  logic [15:0] data_word;
  logic        entered;
  logic        hv_q;
  logic        ls_q;
  logic        pl_q;
  logic        wr_q;
  logic        wr_arm;
  ppp_op_t     op;
  logic [CW-1:0] busy_cnt;
  logic [FA-1:0] sweep;
  logic [7:0]  rd_byte;
  logic        rdy;
  logic [7:0]  dout;
  logic        doe_n;

  wire hv_rise = pins.hv_reset && !hv_q;
  wire [3:0] entry_pat = {pins.page_load_strobe, pins.action_select_hi,
                          pins.action_select_lo, pins.byte_select_a};
  wire ls_rise = entered && pins.load_strobe && !ls_q;
  wire pl_rise = entered && pins.page_load_strobe && !pl_q;
  wire wr_fall = entered && !pins.write_n && wr_q && rdy;
  wire [1:0] act = {pins.action_select_hi, pins.action_select_lo};
  wire [1:0] bsel = {pins.byte_select_b, pins.byte_select_a};
  wire [FW-1:0] fword = addr[FW-1:0];
  wire [EW-1:0] eword = addr[EW-1:0];
  wire [FA-1:0] fpage_base = {addr[FA-1:FW], {FW{1'b0}}};
  wire [EA-1:0] epage_base = {addr[EA-1:EW], {EW{1'b0}}};
  wire [15:0] fword_rd = flash_mem[addr[FA-1:0]];
  wire ee_keep = !fuse[1][PRESERVE_EE_BIT];
  wire [FA-1:0] sweep_nx = sweep + FA'(1);

  function automatic logic [7:0] pick(input logic [15:0] w,
                                      input logic sel_hi);
    pick = sel_hi ? w[15:8] : w[7:0];
  endfunction

  always_comb
  begin
    unique case (cmd)
      CMD_RD_FLASH: rd_byte = pick(fword_rd, pins.byte_select_a);
      CMD_RD_EE:    rd_byte = ee_mem[addr[EA-1:0]];
      CMD_RD_FUSE:
        unique case (bsel)
          2'b00:   rd_byte = fuse[0];
          2'b11:   rd_byte = fuse[1];
          2'b10:   rd_byte = fuse[2];
          default: rd_byte = lock_bits;
        endcase
      CMD_RD_SIG:
        rd_byte = pins.byte_select_a ? CAL_BYTE :
                  addr[1:0] == 2'd0 ? SIG_BYTE0 :
                  addr[1:0] == 2'd1 ? SIG_BYTE1 : SIG_BYTE2;
      default:      rd_byte = 8'h00;
    endcase
  end

  // entry latch and pin edge history
  always_ff @(posedge mclk)
  begin
    hv_q <= pins.hv_reset;
    ls_q <= pins.load_strobe;
    pl_q <= pins.page_load_strobe;
    wr_q <= pins.write_n;
    if (sys_rst || !pins.hv_reset)
      entered <= 1'b0;
    else if (hv_rise && entry_pat == 4'h0)
      entered <= 1'b1;
  end

  // byte loading, command and address retained until reloaded
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !entered)
    begin
      cmd <= CMD_NOP;
      addr <= 16'h0000;
      data_word <= 16'h0000;
      wr_arm <= 1'b0;
      fbuf <= '{default: 16'hffff};
      ebuf <= '{default: 8'hff};
    end
    else
    begin
      if (ls_rise)
        unique case (act)
          ACT_ADDR:
            if (pins.byte_select_a)
              addr[15:8] <= pins.data_bus;
            else
              addr[7:0] <= pins.data_bus;
          ACT_DATA:
            if (pins.byte_select_a)
              data_word[15:8] <= pins.data_bus;
            else
              data_word[7:0] <= pins.data_bus;
          ACT_CMD:
          begin
            cmd <= pins.data_bus;
            wr_arm <= pins.data_bus != CMD_NOP;
          end
          default: ;
        endcase
      if (pl_rise && cmd == CMD_WR_FLASH)
        fbuf[fword] <= data_word;
      if (pl_rise && cmd == CMD_WR_EE)
        ebuf[eword] <= data_word[7:0];
    end
  end

  // internal operations, timed by busy_cnt and, for erase, also by the sweep over flash
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      op <= PPP_OP_IDLE;
      busy_cnt <= '0;
      sweep <= '0;
      rdy <= 1'b1;
      fuse[0] <= FUSE_RESET_LO;
      fuse[1] <= FUSE_RESET_HI;
      fuse[2] <= FUSE_RESET_EXT;
      lock_bits <= LOCK_RESET;
    end
    else
    begin
      unique case (op)
        PPP_OP_IDLE:
          if (wr_fall && wr_arm)
          begin
            rdy <= 1'b0;
            busy_cnt <= CW'(PROG_CYC);
            unique case (cmd)
              CMD_ERASE:
              begin
                op <= PPP_OP_ERASE_MEM;
                busy_cnt <= CW'(ERASE_CYC);
                sweep <= '0;
              end
              CMD_WR_FLASH: op <= PPP_OP_FLASH;
              CMD_WR_EE:
                op <= pins.byte_select_a ? PPP_OP_IDLE : PPP_OP_EE;
              CMD_WR_FUSE:  op <= PPP_OP_FUSE;
              CMD_WR_LOCK:  op <= PPP_OP_LOCK;
              default:      op <= PPP_OP_IDLE;
            endcase
            if (!(cmd inside {CMD_ERASE, CMD_WR_FLASH, CMD_WR_FUSE,
                              CMD_WR_LOCK}) &&
                !(cmd == CMD_WR_EE && !pins.byte_select_a))
              rdy <= 1'b1;
          end
        PPP_OP_ERASE_MEM:
        begin
          flash_mem[sweep] <= 16'hffff;
          if (!ee_keep && sweep < FA'(EE_PAGE_BYTES * EE_PAGES))
            ee_mem[sweep[EA-1:0]] <= 8'hff;
          sweep <= sweep_nx;
          if (busy_cnt != '0)
            busy_cnt <= busy_cnt - CW'(1);
          if (sweep_nx == '0 && busy_cnt <= CW'(1))
            op <= PPP_OP_ERASE_LOCK;
        end
        PPP_OP_ERASE_LOCK:
        begin
          lock_bits <= LOCK_RESET;
          op <= PPP_OP_IDLE;
          rdy <= 1'b1;
        end
        default:
        begin
          busy_cnt <= busy_cnt - CW'(1);
          if (busy_cnt == CW'(1))
          begin
            op <= PPP_OP_IDLE;
            rdy <= 1'b1;
            if (op == PPP_OP_FLASH)
              for (int i = 0; i < FLASH_PAGE_WORDS; i++)
                flash_mem[fpage_base + FA'(i)] <= fbuf[i];
            if (op == PPP_OP_EE)
              for (int i = 0; i < EE_PAGE_BYTES; i++)
                ee_mem[epage_base + EA'(i)] <= ebuf[i];
            if (op == PPP_OP_FUSE)
              unique case (bsel)
                2'b01:   fuse[1] <= data_word[7:0];
                2'b10:   fuse[2] <= data_word[7:0];
                default: fuse[0] <= data_word[7:0];
              endcase
            if (op == PPP_OP_LOCK)
              lock_bits <= lock_bits & data_word[7:0];
          end
        end
      endcase
    end
  end

  // bus drive and outputs, all registered
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      doe_n <= 1'b1;
      dout <= 8'h00;
      prog_mode <= 1'b0;
      prog_active <= 1'b0;
    end
    else
    begin
      doe_n <= !(entered && !pins.output_en_n);
      dout <= rd_byte;
      prog_mode <= entered;
      prog_active <= op != PPP_OP_IDLE;
    end
  end

  assign pins.data_dev_oe_n = doe_n;
  assign pins.data_dev_o = dout;
  assign pins.prog_ready_n_busy = rdy;
endmodule
`default_nettype wire

/* File: core/ppp_host.sv */
/*
  programmer end: enters programming mode, then runs one pin action per
  user request, each a short fixed strobe sequence.
  assumes the device shares mclk and samples pins on it.
*/
`timescale 1ns/1ns
`default_nettype none
module ppp_host
  import ppp_pkg::*;
#(
  parameter int unsigned ENTRY_WAIT = ENTRY_WAIT_CYC
)
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       enter,
  input  wire logic       leave,
  input  wire logic       req_valid,
  input  wire logic [2:0] req_kind,
  input  wire logic [1:0] req_sel,
  input  wire logic [7:0] req_data,
  output logic            req_ready,
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  output logic            in_mode,
  ppp_if.host             pins
);
  import ppp_pkg::*;

  typedef enum logic [2:0] {
    PPH_IDLE, PPH_WAIT, PPH_SETUP, PPH_PULSE, PPH_HOLD, PPH_BUSY
  } ppp_hst_t;

  ppp_hst_t    st;
  logic [31:0] cnt;
  logic [2:0]  kind;
  logic        hv;
  logic        ls;
  logic [1:0]  actp;
  logic [1:0]  bs;
  logic        pl;
  logic        wr_n;
  logic        oe_n;
  logic [7:0]  dq;
  logic        dq_oe_n;

  // kind: 0 addr, 1 data, 2 cmd, 3 page load, 4 write, 5 read
  wire is_load = kind <= 3'd2;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st <= PPH_IDLE;
      cnt <= 32'h0000_0000;
      kind <= 3'd0;
      hv <= 1'b0;
      ls <= 1'b0;
      actp <= 2'b11;
      bs <= 2'b00;
      pl <= 1'b0;
      wr_n <= 1'b1;
      oe_n <= 1'b1;
      dq <= 8'h00;
      dq_oe_n <= 1'b1;
      req_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      in_mode <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      unique case (st)
        PPH_IDLE:
          if (leave)
          begin
            hv <= 1'b0;
            in_mode <= 1'b0;
            req_ready <= 1'b0;
          end
          else if (enter && !hv)
          begin
            actp <= 2'b00;
            bs <= 2'b00;
            pl <= 1'b0;
            hv <= 1'b1;
            cnt <= 32'h0000_0000;
            st <= PPH_WAIT;
          end
          else if (req_valid && req_ready)
          begin
            req_ready <= 1'b0;
            kind <= req_kind;
            bs <= req_sel;
            actp <= req_kind <= 3'd2 ? req_kind[1:0] : 2'b11;
            dq <= req_data;
            dq_oe_n <= req_kind == 3'd5;
            st <= PPH_SETUP;
          end
        PPH_WAIT:
        begin
          cnt <= cnt + 32'h0000_0001;
          if (cnt == ENTRY_WAIT - 1)
          begin
            actp <= 2'b11;
            in_mode <= 1'b1;
            req_ready <= 1'b1;
            st <= PPH_IDLE;
          end
        end
        PPH_SETUP:
        begin
          ls <= is_load;
          pl <= kind == 3'd3;
          wr_n <= kind != 3'd4;
          oe_n <= kind != 3'd5;
          st <= PPH_PULSE;
        end
        PPH_PULSE:
        begin
          ls <= 1'b0;
          pl <= 1'b0;
          wr_n <= 1'b1;
          st <= PPH_HOLD;
        end
        PPH_HOLD:
        begin
          if (kind == 3'd5)
          begin
            rd_data <= pins.data_bus;
            rd_valid <= 1'b1;
          end
          oe_n <= 1'b1;
          dq_oe_n <= 1'b1;
          actp <= 2'b11;
          st <= PPH_BUSY;
        end
        PPH_BUSY:
          if (pins.prog_ready_n_busy)
          begin
            req_ready <= 1'b1;
            st <= PPH_IDLE;
          end
        default: st <= PPH_IDLE;
      endcase
    end
  end

  assign pins.hv_reset = hv;
  assign pins.load_strobe = ls;
  assign pins.action_select_hi = actp[1];
  assign pins.action_select_lo = actp[0];
  assign pins.byte_select_b = bs[1];
  assign pins.byte_select_a = bs[0];
  assign pins.page_load_strobe = pl;
  assign pins.write_n = wr_n;
  assign pins.output_en_n = oe_n;
  assign pins.data_host_o = dq;
  assign pins.data_host_oe_n = dq_oe_n;
endmodule
`default_nettype wire

/* File: tb/ppp_chk_sva.sv */
/*
  checker on the pin bundle between programmer and device.
  assumes one mclk domain and synchronous sys_rst.
*/
`timescale 1ns/1ns
`default_nettype none
module ppp_chk
  import ppp_pkg::*;
(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       hv_reset,
  input wire logic       load_strobe,
  input wire logic       action_select_lo,
  input wire logic       action_select_hi,
  input wire logic       byte_select_a,
  input wire logic       page_load_strobe,
  input wire logic       write_n,
  input wire logic       output_en_n,
  input wire logic       prog_ready_n_busy,
  input wire logic       data_dev_oe_n,
  input wire logic [7:0] data_bus
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  logic [7:0] cmd_q;
  logic       ls_q;
  logic [15:0] busy_cnt;
  wire        take_cmd = load_strobe && !ls_q &&
                         {action_select_hi, action_select_lo} == ACT_CMD;
  wire        cmd_rd = cmd_q == CMD_RD_FLASH || cmd_q == CMD_RD_EE;
  // last loaded command and length of the current busy stretch
  always_ff @(posedge mclk)
  begin
    ls_q     <= load_strobe;
    cmd_q    <= sys_rst ? CMD_NOP : take_cmd ? data_bus : cmd_q;
    busy_cnt <= prog_ready_n_busy ? 16'h0000 : busy_cnt + 16'h0001;
  end
  property p_entry;
    $rose(hv_reset) |-> {page_load_strobe, action_select_hi,
                         action_select_lo, byte_select_a} == 4'h0;
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry pattern not zero");
  property p_oe_off;
    output_en_n [*2] |-> data_dev_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("device drives bus without output enable");
  property p_oe_on;
    $fell(output_en_n) && hv_reset |-> ##[1:2] !data_dev_oe_n;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("device did not drive bus");
  property p_busy_start;
    $fell(write_n) && prog_ready_n_busy &&
      (cmd_q == CMD_WR_FLASH || cmd_q == CMD_ERASE) |-> ##[1:2]
      !prog_ready_n_busy;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("write did not start busy");
  property p_nop;
    $fell(write_n) && prog_ready_n_busy && cmd_q == CMD_NOP |=>
      prog_ready_n_busy [*4];
  endproperty
  a_nop: assert property (p_nop)
    else $error("write after no-op went busy");
  property p_rd_write;
    $fell(write_n) && prog_ready_n_busy && cmd_rd |=>
      prog_ready_n_busy [*4];
  endproperty
  a_rd_write: assert property (p_rd_write)
    else $error("write after read command went busy");
  property p_prog_len;
    $rose(prog_ready_n_busy) && cmd_q == CMD_WR_FLASH |->
      busy_cnt == 16'(PROG_CYC);
  endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("page programming length wrong");
  property p_erase_len;
    $rose(prog_ready_n_busy) && cmd_q == CMD_ERASE |->
      busy_cnt >= 16'(ERASE_CYC) &&
      busy_cnt > 16'(FLASH_PAGE_WORDS * FLASH_PAGES);
  endproperty
  a_erase_len: assert property (p_erase_len)
    else $error("erase ended early");
  property p_busy_cause;
    $fell(prog_ready_n_busy) |->
      !$past(write_n, 1) || !$past(write_n, 2) || !$past(write_n, 3);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy without write pulse");
  property p_busy_end;
    !prog_ready_n_busy |->
      busy_cnt <= 16'(FLASH_PAGE_WORDS * FLASH_PAGES + ERASE_CYC);
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy never ended");
endmodule
`default_nettype wire

/* File: tb/parallel_prog_port_tb.sv */
/*
  testbench: programmer and device joined by the pin bundle.
  assumes the package constants and a 100 mhz mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module parallel_prog_port_tb;
  import ppp_pkg::*;
  localparam logic [2:0] K_ADR = 3'h0;
  localparam logic [2:0] K_DAT = 3'h1;
  localparam logic [2:0] K_CMD = 3'h2;
  localparam logic [2:0] K_PGL = 3'h3;
  localparam logic [2:0] K_WR  = 3'h4;
  localparam logic [2:0] K_RD  = 3'h5;
  logic       mclk;
  logic       sys_rst;
  logic       enter;
  logic       leave;
  logic       req_valid;
  logic [2:0] req_kind;
  logic [1:0] req_sel;
  logic [7:0] req_data;
  logic       req_ready;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       in_mode;
  logic       prog_mode;
  logic       prog_active;
  logic [7:0] got;
  logic       seen;
  int         err_count;
  int         n_compared;
  ppp_if i_ppp_if ();
  ppp_host #(.ENTRY_WAIT(20)) i_ppp_host (.mclk(mclk), .sys_rst(sys_rst),
    .enter(enter), .leave(leave), .req_valid(req_valid),
    .req_kind(req_kind), .req_sel(req_sel), .req_data(req_data),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .in_mode(in_mode), .pins(i_ppp_if.host));
  ppp_device i_ppp_device (.mclk(mclk), .sys_rst(sys_rst),
    .pins(i_ppp_if.dev), .prog_mode(prog_mode), .prog_active(prog_active));
  ppp_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
    .hv_reset(i_ppp_if.hv_reset), .load_strobe(i_ppp_if.load_strobe),
    .action_select_lo(i_ppp_if.action_select_lo),
    .action_select_hi(i_ppp_if.action_select_hi),
    .byte_select_a(i_ppp_if.byte_select_a),
    .page_load_strobe(i_ppp_if.page_load_strobe),
    .write_n(i_ppp_if.write_n), .output_en_n(i_ppp_if.output_en_n),
    .prog_ready_n_busy(i_ppp_if.prog_ready_n_busy),
    .data_dev_oe_n(i_ppp_if.data_dev_oe_n), .data_bus(i_ppp_if.data_bus));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic summarize;
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic give_up;
    err_count++;
    $display("MISMATCH %0t wait ran out", $time);
    summarize();
  endtask
  // one host request; reads leave the byte in got
  task automatic req(input logic [2:0] k, input logic [1:0] s,
                     input logic [7:0] d);
    int i;
    for (i = 0; i < 20000 && req_ready !== 1'b1; i++)
      @(negedge mclk);
    if (req_ready !== 1'b1)
      give_up();
    req_valid = 1'b1;
    req_kind = k;
    req_sel = s;
    req_data = d;
    @(negedge mclk);
    req_valid = 1'b0;
    if (k == K_RD)
    begin
      for (i = 0; i < 20 && rd_valid !== 1'b1; i++)
        @(negedge mclk);
      if (rd_valid !== 1'b1)
        give_up();
      got = rd_data;
    end
  endtask
  task automatic addr(input logic [15:0] a);
    req(K_ADR, 2'b01, a[15:8]);
    req(K_ADR, 2'b00, a[7:0]);
  endtask
  task automatic write_watch;
    int i;
    req(K_WR, 2'b00, 8'h00);
    seen = 1'b0;
    for (i = 0; i < 8; i++)
    begin
      @(negedge mclk);
      seen = seen | (prog_active === 1'b1);
    end
  endtask
  task automatic t_entry;
    int i;
    enter = 1'b1;
    for (i = 0; i < 500 && in_mode !== 1'b1; i++)
      @(negedge mclk);
    if (in_mode !== 1'b1)
      give_up();
    chk({7'h00, prog_mode}, 8'h01);
  endtask
  task automatic t_fuse;
    req(K_CMD, 2'b00, CMD_WR_FUSE);
    req(K_DAT, 2'b00, 8'h3c);
    write_watch();
    chk({7'h00, seen}, 8'h01);
    req(K_DAT, 2'b00, 8'h55);
    req(K_WR, 2'b10, 8'h00);
    req(K_CMD, 2'b00, CMD_WR_LOCK);
    req(K_DAT, 2'b00, 8'hfc);
    req(K_WR, 2'b00, 8'h00);
    req(K_CMD, 2'b00, CMD_RD_FUSE);
    req(K_RD, 2'b00, 8'h00);
    chk(got, 8'h3c);
    req(K_RD, 2'b10, 8'h00);
    chk(got, 8'h55);
    req(K_RD, 2'b11, 8'h00);
    chk(got, FUSE_RESET_HI);
    req(K_RD, 2'b01, 8'h00);
    chk(got, 8'hfc);
    req(K_CMD, 2'b00, CMD_RD_SIG);
    addr(16'h0001);
    req(K_RD, 2'b00, 8'h00);
    chk(got, SIG_BYTE1);
    req(K_RD, 2'b01, 8'h00);
    chk(got, CAL_BYTE);
  endtask
  task automatic t_erase;
    req(K_CMD, 2'b00, CMD_ERASE);
    write_watch();
    chk({7'h00, seen}, 8'h01);
    req(K_CMD, 2'b00, CMD_RD_FLASH);
    addr(16'h0003);
    req(K_RD, 2'b00, 8'h00);
    chk(got, 8'hff);
    req(K_CMD, 2'b00, CMD_RD_FUSE);
    req(K_RD, 2'b00, 8'h00);
    chk(got, 8'h3c);
    req(K_RD, 2'b01, 8'h00);
    chk(got, LOCK_RESET);
  endtask
  task automatic t_flash;
    int i;
    req(K_CMD, 2'b00, CMD_WR_FLASH);
    for (i = 0; i < 2; i++)
    begin
      addr(16'(16'h003e + i));
      req(K_DAT, 2'b00, 8'(8'h10 + i));
      req(K_DAT, 2'b01, 8'(8'hc0 + i));
      req(K_PGL, 2'b01, 8'h00);
    end
    write_watch();
    chk({7'h00, seen}, 8'h01);
    req(K_CMD, 2'b00, CMD_RD_FLASH);
    for (i = 0; i < 2; i++)
    begin
      addr(16'(16'h003e + i));
      req(K_RD, 2'b00, 8'h00);
      chk(got, 8'(8'h10 + i));
      req(K_RD, 2'b01, 8'h00);
      chk(got, 8'(8'hc0 + i));
    end
    addr(16'h007f);
    req(K_RD, 2'b00, 8'h00);
    chk(got, 8'hff);
  endtask
  task automatic t_ee;
    req(K_CMD, 2'b00, CMD_WR_EE);
    addr(16'h0005);
    req(K_DAT, 2'b00, 8'ha5);
    req(K_PGL, 2'b00, 8'h00);
    write_watch();
    chk({7'h00, seen}, 8'h01);
    req(K_CMD, 2'b00, CMD_RD_EE);
    addr(16'h0005);
    req(K_RD, 2'b00, 8'h00);
    chk(got, 8'ha5);
    addr(16'h0004);
    req(K_RD, 2'b00, 8'h00);
    chk(got, 8'hff);
  endtask
  task automatic t_noop;
    logic [7:0] cmds [2] = '{CMD_NOP, CMD_RD_FLASH};
    int         i;
    for (i = 0; i < 2; i++)
    begin
      req(K_CMD, 2'b00, cmds[i]);
      write_watch();
      chk({7'h00, seen}, 8'h00);
    end
  endtask
  task automatic t_leave;
    int i;
    leave = 1'b1;
    for (i = 0; i < 100 && prog_mode !== 1'b0; i++)
      @(negedge mclk);
    if (prog_mode !== 1'b0)
      give_up();
    chk({7'h00, prog_mode}, 8'h00);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    enter = 1'b0;
    leave = 1'b0;
    req_valid = 1'b0;
    req_kind = 3'h0;
    req_sel = 2'h0;
    req_data = 8'h00;
    err_count = 0;
    n_compared = 0;
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    t_entry();
    t_fuse();
    t_erase();
    t_flash();
    t_ee();
    t_noop();
    t_leave();
    summarize();
  end
endmodule
`default_nettype wire
